/* core/rsw_cfg.svh */
// rsw_cfg.svh: constants of the reset source and watchdog block
// assumes a 200 MHz core clock and a 32 kHz low-speed oscillator rate
`ifndef RSW_CFG_SVH
`define RSW_CFG_SVH
`define RSW_CLK_MHZ 200
`define RSW_CLK_HZ 200000000
`define RSW_LOW_SPEED_INTERNAL_OSC_HZ 32000
`define RSW_LOW_SPEED_INTERNAL_OSC_CW 13
`define RSW_POR_DELAY_US 50000
`define RSW_RST_DELAY_US 16700
`define RSW_LV_MIN_NS 1000
`define RSW_LV_MIN_CYC ((`RSW_LV_MIN_NS * `RSW_CLK_MHZ + 999) / 1000)
`define RSW_LV_CW 8
`define RSW_FIRE_CNT 2'h2
`define RSW_OFS_WDT 32'h0000_0000
`define RSW_OFS_LVL 32'h0000_0004
`define RSW_OFS_FLAGS 32'h0000_0008
`define RSW_OFS_STATUS 32'h0000_000C
`define RSW_OFS_CMD 32'h0000_0010
`define RSW_WDT_RESET 8'h53
`define RSW_LVL_RESET 8'h55
`define RSW_KEY_OFF 5'h15
`define RSW_KEY_ON 5'h0A
`define RSW_LVL_V1 8'h55
`define RSW_LVL_V2 8'h33
`define RSW_LVL_V3 8'h99
`define RSW_LVL_V4 8'hAA
`define RSW_KEY_HI 7
`define RSW_KEY_LO 3
`define RSW_RATIO_HI 2
`define RSW_WDT_LIM0 18'h0_00FF
`define RSW_WDT_LIM1 18'h0_03FF
`define RSW_WDT_LIM2 18'h0_0FFF
`define RSW_WDT_LIM3 18'h0_3FFF
`define RSW_WDT_LIM4 18'h0_7FFF
`define RSW_WDT_LIM5 18'h0_FFFF
`define RSW_WDT_LIM6 18'h1_FFFF
`define RSW_WDT_LIM7 18'h3_FFFF
`define RSW_F_LVR 2
`define RSW_F_LVL 1
`define RSW_F_KEY 0
`define RSW_S_PDF 0
`define RSW_S_TO 1
`define RSW_S_WEN 2
`define RSW_S_HOLD 3
`define RSW_C_CLRWDT 0
`define RSW_C_HALT 1
`define RSW_RESP_OKAY 2'h0
`define RSW_RESP_SLVERR 2'h2
`endif

/* core/rsw_pkg.sv */
// rsw_pkg: types shared by the reset source and watchdog modules
// assumes rsw_cfg.svh supplies the numeric constants
package rsw_pkg;
  typedef logic [7:0] rsw_byte_t;
  typedef logic [23:0] rsw_cnt_t;
  typedef logic [17:0] rsw_wdt_t;
  typedef enum {RSW_ST_LOAD, RSW_ST_WAIT, RSW_ST_HOLD, RSW_ST_RUN} rsw_state_e;
endpackage

/* core/rsw_sync.sv */
// rsw_sync: two-stage synchroniser for one asynchronous pin
// assumes the pin is quasi-static against the core clock
`timescale 1ns/1ps
module rsw_sync #(
  parameter bit RST_VAL = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_d,
  output logic o_q
);
  logic meta_reg;

  // the first stage feeds only the second one
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      meta_reg <= RST_VAL;
      o_q <= RST_VAL;
    end
    else
    begin
      meta_reg <= i_d;
      o_q <= meta_reg;
    end
  end
endmodule // rsw_sync

/* core/rsw_delay.sv */
// rsw_delay: down counter that stretches the internal reset
// assumes the caller loads it once per reset and watches o_busy
`timescale 1ns/1ps
module rsw_delay (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_load,
  input wire rsw_pkg::rsw_cnt_t i_count,
  output logic o_busy
);
  import rsw_pkg::*;
  rsw_cnt_t remain_reg;

  // a reload restarts the wait from the full figure
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      remain_reg <= '0;
    else if (i_load)
      remain_reg <= i_count;
    else if (remain_reg != '0)
      remain_reg <= remain_reg - rsw_cnt_t'(1);
  end

  assign o_busy = (remain_reg != '0);
endmodule // rsw_delay

/* core/rsw_top.sv */
// rsw_top: reset source merge, watchdog and low-voltage supervision
// assumes AXI4-Lite software access and asynchronous pins for the reset
// pin, the supply detector and the wake event
//
// Overview of operation
// - key 10101B turns the watchdog off
// - key 01010B turns the watchdog on
// - other key resets device after 2-3 ticks
// - key field powers up as 01010B
// - running time-out: full reset, set time-out flag
// - sleeping time-out: flag, clear PC/SP only
// - bad key, clear command, halt clear counter
// - time-out spans 2^8 to 2^18 ticks
// - power-on reset starts at address zero
// - power-on presets ports to inputs
// - power-on waits 50 ms before running
// - pin release waits 16.7 ms more
// - pin low holds reset, restart at zero
// - pin reset while running keeps context
// - low supply resets and flags it, except in power-down
// - supply dips shorter than minimum ignored
// - bad level resets after 2-3 ticks, flagged
// - level select powers up as 01010101B
// - low-voltage reset off in power-down
// - each cause but the pin recorded in its own flag
// - fault flags set by hardware, cleared by software
// - power-down flag: halt sets, clear command clears
// - three-bit ratio picks 2^8 to 2^18
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "rsw_cfg.svh"
module rsw_top #(
  parameter int POR_DELAY_CYC = `RSW_POR_DELAY_US * `RSW_CLK_MHZ,
  parameter int RST_DELAY_CYC = `RSW_RST_DELAY_US * `RSW_CLK_MHZ,
  parameter int LOW_SPEED_INTERNAL_OSC_DIV = `RSW_CLK_HZ / `RSW_LOW_SPEED_INTERNAL_OSC_HZ
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [31:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [31:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic i_external_reset_pin_n,
  input wire logic i_lowvolt_det,
  input wire logic i_wake,
  output logic o_cpu_hold,
  output logic o_pc_clear,
  output logic o_port_preset,
  output logic o_ctx_keep,
  output logic o_power_down,
  output logic o_wdt_running
);
  import rsw_pkg::*;

  // decoding shared by the write and read paths
  function automatic logic [2:0] reg_index(input logic [31:0] addr);
    unique case (addr)
      `RSW_OFS_WDT: reg_index = 3'h0;
      `RSW_OFS_LVL: reg_index = 3'h1;
      `RSW_OFS_FLAGS: reg_index = 3'h2;
      `RSW_OFS_STATUS: reg_index = 3'h3;
      `RSW_OFS_CMD: reg_index = 3'h4;
      default: reg_index = 3'h7;
    endcase
  endfunction

  function automatic logic key_ok(input rsw_byte_t v);
    key_ok = (v[`RSW_KEY_HI:`RSW_KEY_LO] == `RSW_KEY_ON) ||
      (v[`RSW_KEY_HI:`RSW_KEY_LO] == `RSW_KEY_OFF);
  endfunction

  function automatic logic lvl_ok(input rsw_byte_t v);
    lvl_ok = (v == `RSW_LVL_V1) || (v == `RSW_LVL_V2) ||
      (v == `RSW_LVL_V3) || (v == `RSW_LVL_V4);
  endfunction

  // time-out limit per ratio select; code 110 fills the gap with 2^17
  function automatic rsw_wdt_t wdt_limit(input logic [2:0] sel);
    unique case (sel)
      3'h0: wdt_limit = `RSW_WDT_LIM0;
      3'h1: wdt_limit = `RSW_WDT_LIM1;
      3'h2: wdt_limit = `RSW_WDT_LIM2;
      3'h3: wdt_limit = `RSW_WDT_LIM3;
      3'h4: wdt_limit = `RSW_WDT_LIM4;
      3'h5: wdt_limit = `RSW_WDT_LIM5;
      3'h6: wdt_limit = `RSW_WDT_LIM6;
      3'h7: wdt_limit = `RSW_WDT_LIM7;
    endcase
  endfunction

  rsw_state_e state_reg, state_next;
  rsw_byte_t key_reg, lvl_reg;
  logic [2:0] flags_reg;
  logic to_flag_reg, pdf_reg, pd_mode_reg, por_kind_reg, por_kind_next;
  logic [`RSW_LOW_SPEED_INTERNAL_OSC_CW-1:0] low_speed_internal_osc_cnt_reg;
  rsw_wdt_t wdt_cnt_reg;
  logic [`RSW_LV_CW-1:0] lv_cnt_reg;
  logic [2:0] pins_sync;
  logic pin_low, lv_sync, wake_sync, low_speed_internal_osc_tick, run, delay_busy;
  logic [1:0] bad, fire;
  logic wdt_en, wdt_to, lv_fire, reset_req;
  logic aw_have_reg, w_have_reg;
  logic [31:0] aw_addr_reg, wdata_reg;
  logic wstrb0_reg, wr_do, wr_hit;
  logic [2:0] wr_idx;
  logic ctrl_wr, clr_cmd, halt_cmd;
  logic [31:0] rd_val;

  // pins pass two flops before any reset logic sees them
  localparam logic [2:0] SYNC_RST = 3'h1;
  logic [2:0] pins_raw;
  assign pins_raw = {i_wake, i_lowvolt_det, i_external_reset_pin_n};
  for (genvar g = 0; g < 3; g++)
  begin : g_sync
    rsw_sync #(.RST_VAL(SYNC_RST[g])) u_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_d(pins_raw[g]),
      .o_q(pins_sync[g])
    );
  end
  assign pin_low = !pins_sync[0];
  assign lv_sync = pins_sync[1];
  assign wake_sync = pins_sync[2];
  assign run = (state_reg == RSW_ST_RUN);

  // low-speed oscillator tick derived from the core clock
  always_ff @(posedge i_clk)
  begin
    if (i_rst || low_speed_internal_osc_tick)
      low_speed_internal_osc_cnt_reg <= '0;
    else
      low_speed_internal_osc_cnt_reg <= low_speed_internal_osc_cnt_reg + 1'b1;
  end
  assign low_speed_internal_osc_tick = (low_speed_internal_osc_cnt_reg == `RSW_LOW_SPEED_INTERNAL_OSC_CW'(LOW_SPEED_INTERNAL_OSC_DIV - 1));

  // bad setting fires on the third tick: 2 to 3 periods after it appears
  assign bad[0] = !key_ok(key_reg);
  assign bad[1] = !lvl_ok(lvl_reg);
  for (genvar g = 0; g < 2; g++)
  begin : g_fault
    logic [1:0] tick_cnt_reg;
    always_ff @(posedge i_clk)
    begin
      if (i_rst || !bad[g] || fire[g])
        tick_cnt_reg <= '0;
      else if (low_speed_internal_osc_tick)
        tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
    assign fire[g] = bad[g] && low_speed_internal_osc_tick &&
      (tick_cnt_reg == `RSW_FIRE_CNT);
  end

  // watchdog counts ticks while enabled and the core runs
  assign wdt_en = (key_reg[`RSW_KEY_HI:`RSW_KEY_LO] == `RSW_KEY_ON);
  assign wdt_to = wdt_en && run && low_speed_internal_osc_tick &&
    (wdt_cnt_reg == wdt_limit(key_reg[`RSW_RATIO_HI:0]));
  always_ff @(posedge i_clk)
  begin
    if (i_rst || !run || !wdt_en || fire[0] || clr_cmd || halt_cmd ||
      wdt_to)
      wdt_cnt_reg <= '0;
    else if (low_speed_internal_osc_tick)
      wdt_cnt_reg <= wdt_cnt_reg + 1'b1;
  end

  // supply dip must outlast the minimum time; parked in power-down
  assign lv_fire = lv_sync && run && !pd_mode_reg &&
    (lv_cnt_reg == `RSW_LV_CW'(`RSW_LV_MIN_CYC));
  always_ff @(posedge i_clk)
  begin
    if (i_rst || !lv_sync || !run || pd_mode_reg)
      lv_cnt_reg <= '0;
    else if (lv_cnt_reg != `RSW_LV_CW'(`RSW_LV_MIN_CYC))
      lv_cnt_reg <= lv_cnt_reg + 1'b1;
  end

  // every source funnels into one request for the reset sequence
  assign reset_req = pin_low || lv_fire || (|fire) ||
    (wdt_to && !pd_mode_reg);

  // reset sequence: hold while a source stays active, then delay
  always_comb
  begin
    state_next = state_reg;
    por_kind_next = por_kind_reg;
    unique case (state_reg)
      RSW_ST_LOAD: state_next = RSW_ST_WAIT;
      RSW_ST_WAIT:
        if (pin_low || lv_sync)
          state_next = RSW_ST_HOLD;
        else if (!delay_busy)
        begin
          state_next = RSW_ST_RUN;
          por_kind_next = 1'b0;
        end
      RSW_ST_HOLD:
        if (!pin_low && !lv_sync)
          state_next = RSW_ST_LOAD;
      RSW_ST_RUN:
        if (reset_req)
          state_next = RSW_ST_HOLD;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_reg <= RSW_ST_LOAD;
      por_kind_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      por_kind_reg <= por_kind_next;
    end
  end

  // power-on loads the long delay, every later reset the short one
  rsw_delay u_delay (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_load(state_reg == RSW_ST_LOAD),
    .i_count(por_kind_reg ? rsw_cnt_t'(POR_DELAY_CYC) :
      rsw_cnt_t'(RST_DELAY_CYC)),
    .o_busy(delay_busy)
  );

  // core-facing outputs, all registered; hold, preset and keep from next-state values
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_cpu_hold <= 1'b1;
      o_pc_clear <= 1'b1;
      o_port_preset <= 1'b1;
      o_ctx_keep <= 1'b0;
      o_wdt_running <= 1'b0;
    end
    else
    begin
      o_cpu_hold <= (state_next != RSW_ST_RUN);
      o_pc_clear <= (run && reset_req) || (wdt_to && pd_mode_reg);
      o_port_preset <= por_kind_next && (state_next != RSW_ST_RUN);
      o_ctx_keep <= !por_kind_next;
      o_wdt_running <= wdt_en;
    end
  end

  // command writes only count while the core is running
  assign wr_do = aw_have_reg && w_have_reg && !o_s_axi_bvalid;
  assign wr_idx = reg_index(aw_addr_reg);
  assign wr_hit = wr_do && wstrb0_reg;
  assign ctrl_wr = wr_hit && (wr_idx == 3'h2);
  assign clr_cmd = wr_hit && run && (wr_idx == 3'h4) &&
    wdata_reg[`RSW_C_CLRWDT];
  assign halt_cmd = wr_hit && run && (wr_idx == 3'h4) &&
    wdata_reg[`RSW_C_HALT];

  // setting registers; a bad value is replaced by its reset value
  always_ff @(posedge i_clk)
  begin
    if (i_rst || fire[0])
      key_reg <= `RSW_WDT_RESET;
    else if (wr_hit && wr_idx == 3'h0)
      key_reg <= wdata_reg[7:0];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst || fire[1])
      lvl_reg <= `RSW_LVL_RESET;
    else if (wr_hit && wr_idx == 3'h1)
      lvl_reg <= wdata_reg[7:0];
  end

  // sticky cause flags: writing 0 clears a bit, a new event wins
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      flags_reg <= '0;
    else
      flags_reg <= (flags_reg & ~(ctrl_wr ? ~wdata_reg[2:0] : 3'h0)) |
        {lv_fire, fire[1], fire[0]};
  end

  // time-out and power-down flags, power-down mode
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      to_flag_reg <= 1'b0;
      pdf_reg <= 1'b0;
      pd_mode_reg <= 1'b0;
    end
    else
    begin
      to_flag_reg <= wdt_to || (to_flag_reg && !clr_cmd && !halt_cmd);
      pdf_reg <= halt_cmd || (pdf_reg && !clr_cmd);
      pd_mode_reg <= halt_cmd || (pd_mode_reg && run && !wake_sync &&
        !wdt_to);
    end
  end
  assign o_power_down = pd_mode_reg;

  // write channels are taken independently; one write in flight
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      o_s_axi_awready <= 1'b1;
      o_s_axi_wready <= 1'b1;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= `RSW_RESP_OKAY;
      aw_addr_reg <= 32'h0000_0000;
      wdata_reg <= 32'h0000_0000;
      wstrb0_reg <= 1'b0;
    end
    else
    begin
      if (i_s_axi_awvalid && o_s_axi_awready)
      begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= i_s_axi_awaddr;
        o_s_axi_awready <= 1'b0;
      end
      if (i_s_axi_wvalid && o_s_axi_wready)
      begin
        w_have_reg <= 1'b1;
        wdata_reg <= i_s_axi_wdata;
        wstrb0_reg <= i_s_axi_wstrb[0];
        o_s_axi_wready <= 1'b0;
      end
      if (wr_do)
      begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= (wr_idx == 3'h7) ? `RSW_RESP_SLVERR :
          `RSW_RESP_OKAY;
      end
      if (o_s_axi_bvalid && i_s_axi_bready)
      begin
        o_s_axi_bvalid <= 1'b0;
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready <= 1'b1;
      end
    end
  end

  // read mux; the command register reads as zero
  always_comb
  begin
    unique case (reg_index(i_s_axi_araddr))
      3'h0: rd_val = {24'h00_0000, key_reg};
      3'h1: rd_val = {24'h00_0000, lvl_reg};
      3'h2: rd_val = {29'h0000_0000, flags_reg};
      3'h3: rd_val = {28'h000_0000, o_cpu_hold, wdt_en, to_flag_reg,
        pdf_reg};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h0000_0000;
      o_s_axi_rresp <= `RSW_RESP_OKAY;
    end
    else if (i_s_axi_arvalid && o_s_axi_arready)
    begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rdata <= rd_val;
      o_s_axi_rresp <= (reg_index(i_s_axi_araddr) == 3'h7) ?
        `RSW_RESP_SLVERR : `RSW_RESP_OKAY;
    end
    else if (o_s_axi_rvalid && i_s_axi_rready)
    begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_arready <= 1'b1;
    end
  end

  property p_key_off;
    @(posedge i_clk) disable iff (i_rst)
      (key_reg[`RSW_KEY_HI:`RSW_KEY_LO] == `RSW_KEY_OFF) |=>
        !o_wdt_running && (wdt_cnt_reg == '0);
  endproperty
  a_key_off: assert property (p_key_off) else $error("watchdog not off");

  property p_key_fire;
    @(posedge i_clk) disable iff (i_rst)
      fire[0] |=> flags_reg[`RSW_F_KEY] && o_cpu_hold &&
        (key_reg == `RSW_WDT_RESET);
  endproperty
  a_key_fire: assert property (p_key_fire) else $error("bad key no reset");

  property p_por_key;
    @(posedge i_clk) $fell(i_rst) |->
      (key_reg[`RSW_KEY_HI:`RSW_KEY_LO] == `RSW_KEY_ON) && o_cpu_hold;
  endproperty
  a_por_key: assert property (p_por_key) else $error("key not enabled");

  property p_wdt_normal;
    @(posedge i_clk) disable iff (i_rst)
      (wdt_to && !pd_mode_reg) |=> (o_cpu_hold && to_flag_reg) [*2];
  endproperty
  a_wdt_normal: assert property (p_wdt_normal) else $error("no wdt reset");

  property p_wdt_sleep;
    @(posedge i_clk) disable iff (i_rst)
      (wdt_to && pd_mode_reg) |=>
        to_flag_reg && o_pc_clear && !o_cpu_hold && !o_power_down;
  endproperty
  a_wdt_sleep: assert property (p_wdt_sleep) else $error("bad sleep wake");

  property p_wdt_clear;
    @(posedge i_clk) disable iff (i_rst)
      (clr_cmd || halt_cmd) |=> (wdt_cnt_reg == '0);
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("wdt not cleared");

  property p_pin_hold;
    @(posedge i_clk) disable iff (i_rst)
      pin_low |=> o_cpu_hold;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin low but running");

  property p_lv_qual;
    @(posedge i_clk) disable iff (i_rst)
      $rose(lv_sync) |-> !lv_fire [*8];
  endproperty
  a_lv_qual: assert property (p_lv_qual) else $error("short dip reset");

  property p_lv_pd;
    @(posedge i_clk) disable iff (i_rst)
      o_power_down |-> !lv_fire &&
        (!$past(o_power_down) || (lv_cnt_reg == '0));
  endproperty
  a_lv_pd: assert property (p_lv_pd) else $error("lvr active asleep");

  property p_flag_sticky;
    @(posedge i_clk) disable iff (i_rst)
      (flags_reg[`RSW_F_LVR] && !ctrl_wr) |=> flags_reg[`RSW_F_LVR];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

  property p_pdf;
    @(posedge i_clk) disable iff (i_rst)
      halt_cmd |=> pdf_reg && o_power_down;
  endproperty
  a_pdf: assert property (p_pdf) else $error("halt did not set pdf");
endmodule // rsw_top

/* tb/rsw_pins_model.sv */
// rsw_pins_model: reset pin and supply monitor at the far side
// assumes its tasks are called right after a rising clock edge
`timescale 1ns/1ps
module rsw_pins_model (
  input wire logic i_clk,
  output logic o_pin_n,
  output logic o_lv
);
  // pin idles released high, supply idles healthy
  initial
  begin
    o_pin_n = 1'b1;
    o_lv = 1'b0;
  end
  // hold the pin low for n cycles, then let it go
  task automatic press(input int n);
    o_pin_n <= 1'b0;
    repeat (n) @(posedge i_clk);
    o_pin_n <= 1'b1;
  endtask
  // supply sags into the reset band for n cycles
  task automatic sag(input int n);
    o_lv <= 1'b1;
    repeat (n) @(posedge i_clk);
    o_lv <= 1'b0;
  endtask
endmodule // rsw_pins_model

/* tb/reset_source_and_watchdog_control_tb.sv */
// testbench of rsw_top: bus scenarios, pin and supply resets, watchdog
// assumes shortened delays: 50 and 30 cycles, low-speed tick every 4
`timescale 1ns/1ps
`include "rsw_cfg.svh"
module reset_source_and_watchdog_control_tb;
  logic i_clk, i_rst, i_wake;
  logic [31:0] aw_a, w_d, ar_a, rd;
  logic aw_v, w_v, b_r, ar_v, r_r, awrdy, wrdy, bv, arrdy, rv;
  logic [1:0] br, rr;
  logic pin_n, lv, hold, pcc, pre, keep, pdn, wrun;
  logic [3:0] ws;
  int err_total, comparisons, cyc;

  rsw_top #(.POR_DELAY_CYC(50), .RST_DELAY_CYC(30), .LOW_SPEED_INTERNAL_OSC_DIV(4)) u_rsw_top (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_s_axi_awaddr(aw_a),
    .i_s_axi_awvalid(aw_v),
    .o_s_axi_awready(awrdy),
    .i_s_axi_wdata(w_d),
    .i_s_axi_wstrb(ws),
    .i_s_axi_wvalid(w_v),
    .o_s_axi_wready(wrdy),
    .o_s_axi_bresp(br),
    .o_s_axi_bvalid(bv),
    .i_s_axi_bready(b_r),
    .i_s_axi_araddr(ar_a),
    .i_s_axi_arvalid(ar_v),
    .o_s_axi_arready(arrdy),
    .o_s_axi_rdata(rd),
    .o_s_axi_rresp(rr),
    .o_s_axi_rvalid(rv),
    .i_s_axi_rready(r_r),
    .i_external_reset_pin_n(pin_n),
    .i_lowvolt_det(lv),
    .i_wake(i_wake),
    .o_cpu_hold(hold),
    .o_pc_clear(pcc),
    .o_port_preset(pre),
    .o_ctx_keep(keep),
    .o_power_down(pdn),
    .o_wdt_running(wrun)
  );
  rsw_pins_model u_rsw_pins_model (
    .i_clk(i_clk),
    .o_pin_n(pin_n),
    .o_lv(lv)
  );

  // 200 MHz clock
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // hang guard: well above the longest watchdog run
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_total++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("mismatches %0d of %0d checks", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e,
                     input string m);
    comparisons++;
    if (s !== e)
    begin
      err_total++;
      $display("unexpected at %0t: %s seen %h wanted %h", $time, m, s, e);
    end
  endtask

  task automatic inr(input int n, input int lo, input int hi, input string m);
    chk((n >= lo && n <= hi) ? 32'h1 : 32'h0, 32'h1, m);
  endtask

  // write: address and data offered together, each dropped when taken
  task automatic wreg(input logic [31:0] a, input logic [31:0] d);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    do
    begin
      @(posedge i_clk);
      if (awrdy)
        aw_v <= 1'b0;
      if (wrdy)
        w_v <= 1'b0;
    end
    while (bv !== 1'b1);
    // offsets past the command register answer with an error
    chk(32'(br), (a > `RSW_OFS_CMD) ? 32'h2 : 32'h0, "write resp");
    b_r <= 1'b0;
    @(posedge i_clk);
  endtask

  // read and compare; an extra edge keeps strobes from double assignment
  task automatic rchk(input logic [31:0] a, input logic [31:0] e,
                      input logic [1:0] er, input string m);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do
    begin
      @(posedge i_clk);
      if (arrdy)
        ar_v <= 1'b0;
    end
    while (rv !== 1'b1);
    chk(rd, e, m);
    chk(32'(rr), 32'(er), m);
    r_r <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic waitl(input logic l, input int mx, output int n);
    n = 0;
    while (hold !== l && n < mx)
    begin
      @(posedge i_clk);
      n++;
    end
  endtask

  task automatic t_por();
    int n;
    chk(32'({hold, pcc, pre, keep}), 32'he, "power-on outputs");
    @(posedge i_clk);
    i_rst <= 1'b0;
    waitl(1'b0, 100, n);
    inr(n, 48, 58, "power-on delay");
    wreg(32'h20, 32'h0);
    rchk(`RSW_OFS_WDT, 32'h53, 2'h0, "key reset");
    rchk(`RSW_OFS_LVL, 32'h55, 2'h0, "level reset");
    rchk(`RSW_OFS_FLAGS, 32'h0, 2'h0, "flags reset");
    rchk(`RSW_OFS_STATUS, 32'h4, 2'h0, "status reset");
    rchk(32'h20, 32'h0, 2'h2, "unmapped read");
  endtask

  task automatic t_keys();
    wreg(`RSW_OFS_WDT, 32'ha8);
    chk(32'(wrun), 32'h0, "watchdog off");
    rchk(`RSW_OFS_STATUS, 32'h0, 2'h0, "status off");
    wreg(`RSW_OFS_WDT, 32'h50);
    chk(32'(wrun), 32'h1, "watchdog on");
    wreg(`RSW_OFS_WDT, 32'ha8);
    // a write with the low strobe clear must not reach the key
    ws <= 4'he;
    wreg(`RSW_OFS_WDT, 32'h0);
    ws <= 4'hf;
    rchk(`RSW_OFS_WDT, 32'ha8, 2'h0, "masked write");
  endtask

  task automatic t_pin();
    int n;
    u_rsw_pins_model.press(10);
    chk(32'({hold, keep, pre}), 32'h6, "pin reset");
    waitl(1'b0, 60, n);
    inr(n, 32, 40, "pin delay");
  endtask

  task automatic t_lv();
    int n;
    u_rsw_pins_model.sag(100);
    chk(32'(hold), 32'h0, "short dip");
    u_rsw_pins_model.sag(250);
    chk(32'(hold), 32'h1, "long dip");
    waitl(1'b0, 100, n);
    rchk(`RSW_OFS_FLAGS, 32'h4, 2'h0, "lv flag");
    wreg(`RSW_OFS_FLAGS, 32'h7);
    rchk(`RSW_OFS_FLAGS, 32'h4, 2'h0, "flag kept");
    wreg(`RSW_OFS_FLAGS, 32'h0);
    rchk(`RSW_OFS_FLAGS, 32'h0, 2'h0, "flag cleared");
  endtask

  task automatic t_lvl();
    logic [31:0] tab[4] = '{32'h55, 32'h33, 32'h99, 32'haa};
    int n;
    // every defined level is accepted without a reset
    foreach (tab[i])
    begin
      wreg(`RSW_OFS_LVL, tab[i]);
      rchk(`RSW_OFS_LVL, tab[i], 2'h0, "level kept");
    end
    wreg(`RSW_OFS_LVL, 32'h12);
    waitl(1'b1, 30, n);
    inr(n, 4, 16, "bad level delay");
    waitl(1'b0, 60, n);
    rchk(`RSW_OFS_FLAGS, 32'h2, 2'h0, "level flag");
    rchk(`RSW_OFS_LVL, 32'h55, 2'h0, "level reload");
    wreg(`RSW_OFS_FLAGS, 32'h0);
  endtask

  task automatic t_wdt(input int sel);
    int lim = (1 << (8 + 2 * sel)) * 4;
    int n;
    wreg(`RSW_OFS_WDT, 32'h50 | sel);
    // clears inside the period keep the core running
    repeat (2)
    begin
      wreg(`RSW_OFS_CMD, 32'h1);
      repeat (lim - 100) @(posedge i_clk);
    end
    chk(32'(hold), 32'h0, "cleared in time");
    wreg(`RSW_OFS_CMD, 32'h1);
    waitl(1'b1, lim + 40, n);
    inr(n, lim - 8, lim + 12, "time-out period");
    waitl(1'b0, 60, n);
    rchk(`RSW_OFS_STATUS, 32'h6, 2'h0, "time-out flag");
    wreg(`RSW_OFS_WDT, 32'ha8);
    wreg(`RSW_OFS_CMD, 32'h1);
    rchk(`RSW_OFS_STATUS, 32'h0, 2'h0, "flag cleared");
  endtask

  task automatic t_sleep();
    int n;
    logic hs, ps;
    wreg(`RSW_OFS_WDT, 32'h50);
    wreg(`RSW_OFS_CMD, 32'h2);
    rchk(`RSW_OFS_STATUS, 32'h5, 2'h0, "halt status");
    hs = 1'b0;
    ps = 1'b0;
    n = 0;
    // time-out while asleep only pulses the program counter clear
    while (pdn === 1'b1 && n < 1200)
    begin
      @(posedge i_clk);
      n++;
      hs = hs | hold;
      ps = ps | pcc;
    end
    chk(32'({hs, ps}), 32'h1, "sleep time-out");
    inr(n, 1000, 1040, "halt cleared count");
    rchk(`RSW_OFS_STATUS, 32'h7, 2'h0, "sleep flags");
    wreg(`RSW_OFS_CMD, 32'h1);
    rchk(`RSW_OFS_STATUS, 32'h4, 2'h0, "clear command");
    wreg(`RSW_OFS_WDT, 32'ha8);
    wreg(`RSW_OFS_CMD, 32'h2);
    u_rsw_pins_model.sag(250);
    chk(32'(hold), 32'h0, "no lv in power-down");
    i_wake <= 1'b1;
    repeat (5) @(posedge i_clk);
    i_wake <= 1'b0;
    chk(32'(pdn), 32'h0, "wake");
    rchk(`RSW_OFS_FLAGS, 32'h0, 2'h0, "no lv flag");
  endtask

  task automatic t_badkey();
    int n;
    wreg(`RSW_OFS_WDT, 32'h0);
    waitl(1'b1, 30, n);
    inr(n, 4, 16, "bad key delay");
    waitl(1'b0, 60, n);
    rchk(`RSW_OFS_FLAGS, 32'h1, 2'h0, "key flag");
    rchk(`RSW_OFS_WDT, 32'h53, 2'h0, "key reload");
  endtask

  // main sequence: reset held four edges inside t_por
  initial
  begin
    i_rst = 1'b1;
    i_wake = 1'b0;
    {aw_a, w_d, ar_a} = '0;
    {aw_v, w_v, b_r, ar_v, r_r} = '0;
    {err_total, comparisons} = '0;
    ws = 4'hf;
    repeat (3) @(posedge i_clk);
    t_por();
    t_keys();
    t_pin();
    t_lv();
    t_lvl();
    t_wdt(0);
    t_wdt(1);
    t_sleep();
    t_badkey();
    wrap_up();
  end
endmodule // reset_source_and_watchdog_control_tb
